// >>> core/dbs_data_port.sv
// burst sram data port: load decode, ddr write capture, ddr read launch
// assumes bus clock pins are synchronous levels sampled by core_clk,
// running well below core_clk so every pin edge is seen once
// Functional notes
// - capture write words on both input clock rises
// - launch read words on both output clock rises
// - single clock mode launches on input clocks
// - data drivers float from the next launch rise with no read active
// - data bus 18 or 36 bits wide
// - address and direction latched with load strobe
// - every transaction moves exactly two words
// - direction high reads, low writes when loaded
// - accesses start on positive input clock rise
// - burst lsb counter gives second word address
// - byte selects high leave array bytes unchanged

`timescale 1ns/1ps

// ==========================================================
// write buffer
module dbs_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [PW-1:0] wr_ptr_ff;
  logic [PW-1:0] rd_ptr_ff;
  logic [PW:0] count_ff;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;

  assign in_ready = count_ff != (PW+1)'(DEPTH);
  assign out_valid = count_ff != '0;
  assign out_data = mem_ff[rd_ptr_ff];

  always_ff @(posedge core_clk) begin
    if (push) begin
      mem_ff[wr_ptr_ff] <= in_data;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff <= '0;
    end else begin
      if (push) wr_ptr_ff <= (wr_ptr_ff == PW'(DEPTH-1)) ? '0 : wr_ptr_ff + 1'b1;
      if (pop) rd_ptr_ff <= (rd_ptr_ff == PW'(DEPTH-1)) ? '0 : rd_ptr_ff + 1'b1;
      count_ff <= count_ff + (PW+1)'(push) - (PW+1)'(pop);
    end
  end
endmodule

// ==========================================================
// data port top
module dbs_data_port #(
  parameter int DATA_W = dbs_pkg::DQ_W_NARROW,
  parameter int ADDR_W = dbs_pkg::ADDR_W_NARROW,
  parameter int FIFO_DEPTH = dbs_pkg::WR_FIFO_DEPTH
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // bus clocks and mode
  input wire dbs_pkg::dbs_clk_pins_t clk_pins,
  input wire logic single_clock_mode,
  // command
  input wire logic load_strobe_n,
  input wire logic rw_dir,
  input wire logic [ADDR_W-2:0] addr_hi,
  input wire logic burst_lsb_address,
  input wire logic [DATA_W/dbs_pkg::LANE_W-1:0] byte_write_select_n,
  // data pins
  input wire logic [DATA_W-1:0] dq_in,
  output logic [DATA_W-1:0] dq_out,
  output logic dq_oe,
  // buffer status
  output logic write_buffer_ready
);
  import dbs_pkg::*;

  localparam int LANES = DATA_W / LANE_W;
  localparam int EW = $bits(dbs_wr_entry_t);

  // ==========================================================
  // clock pin edges
  dbs_clk_pins_t pins_q_ff;
  always_ff @(posedge core_clk) begin
    if (rst) pins_q_ff <= '0;
    else pins_q_ff <= clk_pins;
  end
  wire k_rise = clk_pins.k && !pins_q_ff.k;
  wire kn_rise = clk_pins.kn && !pins_q_ff.kn;
  wire c_rise = clk_pins.c && !pins_q_ff.c;
  wire cn_rise = clk_pins.cn && !pins_q_ff.cn;
  // read launch edges follow the input clocks in single clock mode
  wire lpos = single_clock_mode ? k_rise : c_rise;
  wire lneg = single_clock_mode ? kn_rise : cn_rise;

  // ==========================================================
  // load decode
  wire [ADDR_W-1:0] addr_in = {addr_hi, burst_lsb_address};
  wire load = k_rise && !load_strobe_n;
  wire rd_load = load && rw_dir;
  wire wr_load = load && !rw_dir;

  // ==========================================================
  // array
  logic [DATA_W-1:0] array_ff [2**ADDR_W];
  dbs_wr_entry_t drain_entry;
  logic drain_valid;
  // a read load owns the array port, so the drain waits one cycle
  wire drain_ready = !rd_load;
  wire drain = drain_valid && drain_ready;
  wire [ADDR_W-1:0] drain_addr = drain_entry.addr[ADDR_W-1:0];

  // lanes are merged first so that one process alone owns the array
  wire [DATA_W-1:0] drain_old = array_ff[drain_addr];
  wire [DATA_W-1:0] drain_word;
  for (genvar g = 0; g < LANES; g++) begin : g_lane
    assign drain_word[g*LANE_W +: LANE_W] = drain_entry.bws_n[g] ?
      drain_old[g*LANE_W +: LANE_W] :
      drain_entry.data[g*LANE_W +: LANE_W];
  end

  always_ff @(posedge core_clk) begin
    if (drain) begin
      array_ff[drain_addr] <= drain_word;
    end
  end

  // ==========================================================
  // write capture
  dbs_wr_state_t ws_ff, nxt_ws;
  logic [ADDR_W-1:0] wa_ff, nxt_wa;
  logic [ADDR_W-1:0] wpend_addr_ff, nxt_wpend_addr;
  logic wpend_ff, nxt_wpend;
  dbs_wr_entry_t push_entry;
  logic push_ready;
  wire push_w0 = k_rise && ws_ff == DBS_W_WORD0;
  wire push_w1 = kn_rise && ws_ff == DBS_W_WORD1;
  wire push_valid = push_w0 || push_w1;
  // second word flips the burst lsb, wrapping inside the pair
  wire [ADDR_W-1:0] push_addr = push_w1 ? {wa_ff[ADDR_W-1:1], !wa_ff[0]}
                                        : wa_ff;

  always_comb begin
    push_entry = '0;
    push_entry.addr = MAX_ADDR_W'(push_addr);
    push_entry.data = MAX_DQ_W'(dq_in);
    push_entry.bws_n = MAX_LANES'(byte_write_select_n);
  end

  always_comb begin
    nxt_ws = ws_ff;
    nxt_wa = wa_ff;
    nxt_wpend = wpend_ff;
    nxt_wpend_addr = wpend_addr_ff;
    case (ws_ff)
      DBS_W_WORD0: if (k_rise) nxt_ws = DBS_W_WORD1;
      DBS_W_WORD1: begin
        if (kn_rise) begin
          nxt_ws = wpend_ff ? DBS_W_WORD0 : DBS_W_IDLE;
          nxt_wa = wpend_addr_ff;
          nxt_wpend = 1'b0;
        end
      end
      default: ;
    endcase
    if (wr_load) begin
      if (ws_ff == DBS_W_IDLE) begin
        nxt_ws = DBS_W_WORD0;
        nxt_wa = addr_in;
      end else begin
        nxt_wpend = 1'b1;
        nxt_wpend_addr = addr_in;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      ws_ff <= DBS_W_IDLE;
      wa_ff <= '0;
      wpend_ff <= 1'b0;
      wpend_addr_ff <= '0;
    end else begin
      ws_ff <= nxt_ws;
      wa_ff <= nxt_wa;
      wpend_ff <= nxt_wpend;
      wpend_addr_ff <= nxt_wpend_addr;
    end
  end

  logic [EW-1:0] drain_bits;
  dbs_fifo #(.WIDTH(EW), .DEPTH(FIFO_DEPTH)) u_wr_fifo (
    .core_clk(core_clk),
    .rst(rst),
    .in_valid(push_valid),
    .in_ready(push_ready),
    .in_data(push_entry),
    .out_valid(drain_valid),
    .out_ready(drain_ready),
    .out_data(drain_bits)
  );
  assign drain_entry = dbs_wr_entry_t'(drain_bits);
  assign write_buffer_ready = push_ready;

  // ==========================================================
  // read launch
  dbs_rd_state_t rs_ff, nxt_rs;
  dbs_burst_t cur_ff, nxt_cur, rpend_ff, nxt_rpend;
  logic rpend_v_ff, nxt_rpend_v;
  logic [DATA_W-1:0] dq_ff, nxt_dq;
  logic oe_ff, nxt_oe;
  dbs_burst_t fetch;
  wire [ADDR_W-1:0] addr_pair = {addr_hi, !burst_lsb_address};

  always_comb begin
    fetch.w0 = MAX_DQ_W'(array_ff[addr_in]);
    fetch.w1 = MAX_DQ_W'(array_ff[addr_pair]);
  end

  always_comb begin
    nxt_rs = rs_ff;
    nxt_cur = cur_ff;
    nxt_rpend = rpend_ff;
    nxt_rpend_v = rpend_v_ff;
    nxt_dq = dq_ff;
    nxt_oe = oe_ff;
    if (lpos) begin
      if (rs_ff == DBS_R_WORD0) begin
        nxt_dq = cur_ff.w0[DATA_W-1:0];
        nxt_oe = 1'b1;
        nxt_rs = DBS_R_WORD1;
      end else if (rs_ff == DBS_R_IDLE) begin
        nxt_oe = 1'b0;
      end
    end
    if (lneg && rs_ff == DBS_R_WORD1) begin
      nxt_dq = cur_ff.w1[DATA_W-1:0];
      nxt_rs = rpend_v_ff ? DBS_R_WORD0 : DBS_R_IDLE;
      nxt_cur = rpend_ff;
      nxt_rpend_v = 1'b0;
    end
    if (rd_load) begin
      if (nxt_rs == DBS_R_IDLE) begin
        nxt_cur = fetch;
        nxt_rs = DBS_R_WORD0;
      end else begin
        nxt_rpend = fetch;
        nxt_rpend_v = 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      rs_ff <= DBS_R_IDLE;
      cur_ff <= '0;
      rpend_ff <= '0;
      rpend_v_ff <= 1'b0;
      dq_ff <= '0;
      oe_ff <= 1'b0;
    end else begin
      rs_ff <= nxt_rs;
      cur_ff <= nxt_cur;
      rpend_ff <= nxt_rpend;
      rpend_v_ff <= nxt_rpend_v;
      dq_ff <= nxt_dq;
      oe_ff <= nxt_oe;
    end
  end
  assign dq_out = dq_ff;
  assign dq_oe = oe_ff;

  // ==========================================================
  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  chk_wr_word0_cap: assert property (
    push_w0 |-> push_valid ##1 ws_ff == DBS_W_WORD1)
    else $error("word0 capture did not advance to word1");
  chk_wr_word1_addr: assert property (
    push_w1 |-> push_valid && push_entry.addr[0] != wa_ff[0])
    else $error("second write word lsb not flipped");
  chk_rd_word0_out: assert property (
    lpos && rs_ff == DBS_R_WORD0 |=>
      dq_oe && dq_out == $past(cur_ff.w0[DATA_W-1:0]))
    else $error("first read word not launched");
  chk_rd_word1_out: assert property (
    lneg && rs_ff == DBS_R_WORD1 |=>
      dq_oe && dq_out == $past(cur_ff.w1[DATA_W-1:0]))
    else $error("second read word not launched");
  chk_single_clk_edge: assert property (
    single_clock_mode |-> lpos == k_rise && lneg == kn_rise)
    else $error("single clock mode not on input clocks");
  chk_idle_hiz: assert property (
    lpos && rs_ff == DBS_R_IDLE && !rd_load |=> !dq_oe [*2])
    else $error("drivers on with no read selected");
  chk_no_load_idle: assert property (
    k_rise && load_strobe_n && ws_ff == DBS_W_IDLE |=> ws_ff == DBS_W_IDLE)
    else $error("write started without load strobe");
  chk_rd_load_start: assert property (
    rd_load && rs_ff == DBS_R_IDLE |=>
      rs_ff == DBS_R_WORD0 && $stable(dq_out) && !$rose(dq_oe))
    else $error("read load not taken");

  cov_write_burst: cover property (push_w0 ##[1:40] push_w1);
  cov_read_burst: cover property (
    rd_load ##[1:40] (lneg && rs_ff == DBS_R_WORD1));
  cov_read_pending: cover property (rd_load && rs_ff != DBS_R_IDLE);
  cov_fifo_full: cover property (!write_buffer_ready);
endmodule

// >>> core/dbs_pkg.sv
// shared constants and carrier types for the burst sram data port
// assumes one core clock; the bus clock pins arrive as sampled levels

package dbs_pkg;

  // ==========================================================
  // organisation
  localparam int DQ_W_NARROW = 18;
  localparam int DQ_W_WIDE = 36;
  localparam int ADDR_W_NARROW = 21;
  localparam int ADDR_W_WIDE = 20;
  localparam int LANE_W = 9;
  localparam int MAX_DQ_W = DQ_W_WIDE;
  localparam int MAX_ADDR_W = ADDR_W_NARROW;
  localparam int MAX_LANES = MAX_DQ_W / LANE_W;
  localparam int BURST_LEN = 2;
  localparam int WR_FIFO_DEPTH = 4;

  // ==========================================================
  // carriers
  typedef struct packed {
    logic k;
    logic kn;
    logic c;
    logic cn;
  } dbs_clk_pins_t;

  typedef struct packed {
    logic [MAX_ADDR_W-1:0] addr;
    logic [MAX_DQ_W-1:0] data;
    logic [MAX_LANES-1:0] bws_n;
  } dbs_wr_entry_t;

  typedef struct packed {
    logic [MAX_DQ_W-1:0] w0;
    logic [MAX_DQ_W-1:0] w1;
  } dbs_burst_t;

  typedef enum {DBS_W_IDLE, DBS_W_WORD0, DBS_W_WORD1} dbs_wr_state_t;
  typedef enum {DBS_R_IDLE, DBS_R_WORD0, DBS_R_WORD1} dbs_rd_state_t;

endpackage

// >>> tb/dbs_ctl_model.sv
// controller model for the burst sram data port: bus clocks and bursts
// assumes core_clk runs four times the bus clock, inputs move at negedge
`timescale 1ns/1ps

module dbs_ctl_model
  import dbs_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // bus side
  output dbs_pkg::dbs_clk_pins_t clk_pins,
  output logic load_strobe_n,
  output logic rw_dir,
  output logic [4:0] addr_hi,
  output logic burst_lsb_address,
  output logic [1:0] byte_write_select_n,
  output logic [17:0] ctl_dq
);
  logic [1:0] ph_ff;

  // ==========================================================
  // free running bus clocks, each level two core cycles long
  always_ff @(negedge core_clk) begin
    if (rst) begin
      ph_ff <= 2'h0;
    end else begin
      ph_ff <= ph_ff + 2'h1;
    end
  end
  assign clk_pins.k = !rst && !ph_ff[1];
  assign clk_pins.kn = !rst && ph_ff[1];
  assign clk_pins.c = !rst && (ph_ff == 2'h1 || ph_ff == 2'h2);
  assign clk_pins.cn = !rst && (ph_ff == 2'h3 || ph_ff == 2'h0);

  initial begin
    load_strobe_n = 1'b1;
    rw_dir = 1'b0;
    {addr_hi, burst_lsb_address} = 6'h00;
    byte_write_select_n = 2'h3;
    ctl_dq = 18'h00000;
  end

  // ==========================================================
  // bursts
  task automatic at_ph(input logic [1:0] p);
    do begin
      @(negedge core_clk);
      #1;
    end while (ph_ff !== p);
  endtask

  // load at a k rise; a write then sends two words on k and kn rises
  task automatic burst(input logic ld_n, input logic rd, input logic [5:0] a,
    input logic [17:0] w0, input logic [17:0] w1, input logic [1:0] b0,
    input logic [1:0] b1);
    at_ph(2'h0);
    load_strobe_n = ld_n;
    rw_dir = rd;
    {addr_hi, burst_lsb_address} = a;
    at_ph(rd ? 2'h1 : 2'h0);
    load_strobe_n = 1'b1;
    rw_dir = ~rd;
    {addr_hi, burst_lsb_address} = ~a;
    if (!rd) begin
      ctl_dq = w0;
      byte_write_select_n = b0;
      at_ph(2'h2);
      ctl_dq = w1;
      byte_write_select_n = b1;
      at_ph(2'h3);
    end
    // released lines show a changed value, never the stale one
    ctl_dq = ~ctl_dq;
    byte_write_select_n = ~byte_write_select_n;
  endtask
endmodule

// >>> tb/dbs_data_port_tb_top.sv
// self-checking bench for the burst sram data port, narrow organisation
// assumes the controller model in dbs_ctl_model drives the bus side
`timescale 1ns/1ps

module dbs_data_port_tb_top;
  import dbs_pkg::*;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic single_clock_mode = 1'b0;
  dbs_clk_pins_t clk_pins;
  logic load_strobe_n, rw_dir, burst_lsb_address, dq_oe, write_buffer_ready;
  logic [4:0] addr_hi;
  logic [1:0] byte_write_select_n;
  logic [17:0] ctl_dq, dq_out;
  wire logic [17:0] dq_wire = dq_oe ? dq_out : ctl_dq;
  int bad_count = 0;
  int compares = 0;

  always #5 core_clk = ~core_clk;

  dbs_ctl_model ctl (.core_clk(core_clk), .rst(rst), .clk_pins(clk_pins),
    .load_strobe_n(load_strobe_n), .rw_dir(rw_dir), .addr_hi(addr_hi),
    .burst_lsb_address(burst_lsb_address),
    .byte_write_select_n(byte_write_select_n), .ctl_dq(ctl_dq));

  dbs_data_port #(.DATA_W(18), .ADDR_W(6), .FIFO_DEPTH(4)) dut (
    .core_clk(core_clk), .rst(rst), .clk_pins(clk_pins),
    .single_clock_mode(single_clock_mode), .load_strobe_n(load_strobe_n),
    .rw_dir(rw_dir), .addr_hi(addr_hi),
    .burst_lsb_address(burst_lsb_address),
    .byte_write_select_n(byte_write_select_n), .dq_in(dq_wire),
    .dq_out(dq_out), .dq_oe(dq_oe),
    .write_buffer_ready(write_buffer_ready));

  // ==========================================================
  // checking
  task automatic cmp_w(input string what, input logic [17:0] exp,
    input logic [17:0] got);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic cmp_b(input string what, input logic exp, input logic got);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic give_verdict;
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // bounded wait for the driver enable to reach a level
  task automatic wait_oe(input logic v);
    int n = 0;
    while (dq_oe !== v && n < 16) begin
      @(negedge core_clk);
      #1;
      n++;
    end
  endtask

  // ==========================================================
  // scenarios
  task automatic wr(input logic [5:0] a, input logic [17:0] w0,
    input logic [17:0] w1, input logic [1:0] b0, input logic [1:0] b1);
    ctl.burst(1'b0, 1'b0, a, w0, w1, b0, b1);
    cmp_b("oe during write", 1'b0, dq_oe);
  endtask

  // word0 lands one cycle after the launch rise, word1 two cycles later
  task automatic rd_pair(input logic [5:0] a, input logic [17:0] e0,
    input logic [17:0] e1);
    ctl.burst(1'b0, 1'b1, a, 18'h0, 18'h0, 2'h3, 2'h3);
    wait_oe(1'b1);
    cmp_b("oe on read", 1'b1, dq_oe);
    cmp_w("launch phase", single_clock_mode ? 18'h1 : 18'h2,
      {16'h0, ctl.ph_ff});
    cmp_w("word0", e0, dq_out);
    repeat (2) @(negedge core_clk);
    cmp_w("word1", e1, dq_out);
    wait_oe(1'b0);
    cmp_b("oe after read", 1'b0, dq_oe);
  endtask

  task automatic t_reset;
    cmp_b("oe at reset", 1'b0, dq_oe);
    cmp_w("dq_out at reset", 18'h0, dq_out);
    cmp_b("buffer ready", 1'b1, write_buffer_ready);
    cmp_w("bus width", 18'h12, 18'($bits(dut.dq_out)));
  endtask

  task automatic t_write_read;
    wr(6'h0A, 18'h1A5A5, 18'h2C3C3, 2'h0, 2'h0);
    rd_pair(6'h0A, 18'h1A5A5, 18'h2C3C3);
    rd_pair(6'h0B, 18'h2C3C3, 18'h1A5A5);
    wr(6'h15, 18'h00F0F, 18'h3F0F0, 2'h0, 2'h0);
    rd_pair(6'h14, 18'h3F0F0, 18'h00F0F);
  endtask

  task automatic t_byte_lanes;
    wr(6'h0A, 18'h3FFFF, 18'h3FFFF, 2'h1, 2'h2);
    rd_pair(6'h0A, 18'h3FE00 | (18'h1A5A5 & 18'h001FF),
      18'h001FF | (18'h2C3C3 & 18'h3FE00));
  endtask

  // a cycle with load high must not write even with a write direction
  task automatic t_load_high;
    ctl.burst(1'b1, 1'b0, 6'h14, 18'h12345, 18'h0ABCD, 2'h0, 2'h0);
    cmp_b("oe on idle", 1'b0, dq_oe);
    rd_pair(6'h14, 18'h3F0F0, 18'h00F0F);
  endtask

  task automatic t_single;
    single_clock_mode = 1'b1;
    rd_pair(6'h0A, 18'h3FE00 | (18'h1A5A5 & 18'h001FF),
      18'h001FF | (18'h2C3C3 & 18'h3FE00));
    // loads on consecutive k rises: the second one waits as pending
    ctl.burst(1'b0, 1'b1, 6'h14, 18'h0, 18'h0, 2'h3, 2'h3);
    ctl.burst(1'b0, 1'b1, 6'h0B, 18'h0, 18'h0, 2'h3, 2'h3);
    cmp_w("b2b word0", 18'h3F0F0, dq_out);
    repeat (2) @(negedge core_clk);
    cmp_w("b2b word1", 18'h00F0F, dq_out);
    repeat (2) @(negedge core_clk);
    cmp_w("b2b second word0",
      18'h001FF | (18'h2C3C3 & 18'h3FE00), dq_out);
    repeat (2) @(negedge core_clk);
    cmp_w("b2b second word1",
      18'h3FE00 | (18'h1A5A5 & 18'h001FF), dq_out);
    wait_oe(1'b0);
    cmp_b("oe after b2b", 1'b0, dq_oe);
    single_clock_mode = 1'b0;
  endtask

  // ==========================================================
  // main sequence and watchdog
  initial begin
    repeat (10) @(negedge core_clk);
    rst <= 1'b0;
    t_reset;
    t_write_read;
    t_byte_lanes;
    t_load_high;
    t_single;
    give_verdict;
  end

  initial begin
    #20000;
    bad_count++;
    $display("[ERR] watchdog expected finish seen hang");
    give_verdict;
  end
endmodule
